// file: design/dism_pkg.sv
// Constants and types for the interrupt service mode block
package dism_pkg;
    localparam int          DISM_VEC_W     = 8;
    localparam int          DISM_CAUSE_W   = 8;
    localparam logic [7:0]  DISM_VEC_RST   = 8'h0F;
    localparam logic [7:0]  DISM_MASK_RST  = 8'h00;
    localparam int          DISM_SYNC_LEN  = 3;
    typedef enum logic [1:0] {
        DISM_CMD_NONE,
        DISM_CMD_SET_VECTOR,
        DISM_CMD_SET_PLAIN
    } dism_cmd_type;
endpackage

// file: design/dism_sync.sv
// Three-stage synchroniser with agreement filter for pin inputs
`timescale 1ns/10ps
`default_nettype none
module dism_sync
#(
    parameter logic RST_VAL = 1'b1
)
(
    // Clock and reset
    input  wire logic clk,
    input  wire logic rst_n,
    // Pin in, filtered level out
    input  wire logic din,
    output var  logic dout
);
    import dism_pkg::*;

    typedef struct packed {
        logic [DISM_SYNC_LEN-1:0] stg;
        logic                     lvl;
    } dism_sync_type;

    dism_sync_type s_r;
    dism_sync_type s_nxt;

    always_comb
    begin
        s_nxt     = s_r;
        s_nxt.stg = {s_r.stg[DISM_SYNC_LEN-2:0], din};
        // Only second and third stages are looked at
        if (s_r.stg[1] == s_r.stg[2])
        begin
            s_nxt.lvl = s_r.stg[1];
        end
    end

    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            s_r <= '{stg: {DISM_SYNC_LEN{RST_VAL}}, lvl: RST_VAL};
        end
        else
        begin
            s_r <= s_nxt;
        end
    end

    assign dout = s_r.lvl;
endmodule
`default_nettype wire

// file: design/dism_top.sv
// Interrupt request and acknowledge logic with two service modes
// How it works
// - Vector mode: drive 8-bit vector during acknowledge
// - Plain mode: no vector during acknowledge
// - Reset leaves device in plain mode
// - Vector mode entered only by command
// - Request asserted when enabled cause pending
// - Request held until all enabled causes cleared
// - Plain mode needs no acknowledge handshake
// - Vector mode joins hardware priority chain
// - Vector register readable, writable; vector source
// - Request from status AND mask only
// - Request output is active low
`timescale 1ns/10ps
`default_nettype none
module dism_top
#(
    parameter int CAUSE_W = dism_pkg::DISM_CAUSE_W
)
(
    // Clock and reset
    input  wire logic                        MCLK,
    input  wire logic                        RESETN,
    // Cause status and mask, same clock domain
    input  wire logic [CAUSE_W-1:0]          PENDING_CAUSE_FLAGS,
    input  wire logic [CAUSE_W-1:0]          CAUSE_ENABLE_MASK_WR,
    input  wire logic                        CAUSE_ENABLE_MASK_WE,
    output var  logic [CAUSE_W-1:0]          MASKED_CAUSE_FLAGS,
    // Mode command and vector register access
    input  wire dism_pkg::dism_cmd_type      MODE_CMD,
    input  wire logic [dism_pkg::DISM_VEC_W-1:0] VECTOR_WR,
    input  wire logic                        VECTOR_WE,
    output var  logic [dism_pkg::DISM_VEC_W-1:0] VECTOR_VALUE_REG,
    output var  logic                        VECTOR_MODE,
    // Priority chain, active low, from pins
    input  wire logic                        PRIO_IN_N,
    output var  logic                        PRIO_OUT_N,
    // Host acknowledge pin and interrupt request
    input  wire logic                        HOST_INT_ACK_N,
    output var  logic                        IRQ_OUT_N,
    // Data bus toward host
    output var  logic [dism_pkg::DISM_VEC_W-1:0] DATA_OUT,
    output var  logic                        DATA_OE
);
    import dism_pkg::*;

    // Wider masks would not fit one host-visible status word
    if (CAUSE_W < 1 || CAUSE_W > 32)
    begin : g_bad_width
        $error("CAUSE_W out of range");
    end

    // Same AND feeds the request and the readback register
    function automatic logic [CAUSE_W-1:0] masked_of
    (
        input logic [CAUSE_W-1:0] stat,
        input logic [CAUSE_W-1:0] msk
    );
        return stat & msk;
    endfunction

    typedef struct packed {
        logic                  vec_mode;
        logic [DISM_VEC_W-1:0] vec;
        logic [CAUSE_W-1:0]    mask;
        logic [CAUSE_W-1:0]    masked;
        logic                  irq_n;
        logic                  prio_out_n;
        logic [DISM_VEC_W-1:0] dout;
        logic                  oe;
    } dism_state_type;

    dism_state_type st_r;
    dism_state_type st_nxt;
    logic           ack_n;
    logic           prio_in_n;
    logic           req;

    dism_sync #(.RST_VAL(1'b1)) u_ack_sync
    (
        .clk   (MCLK),
        .rst_n (RESETN),
        .din   (HOST_INT_ACK_N),
        .dout  (ack_n)
    );

    dism_sync #(.RST_VAL(1'b1)) u_prio_sync
    (
        .clk   (MCLK),
        .rst_n (RESETN),
        .din   (PRIO_IN_N),
        .dout  (prio_in_n)
    );

    // Pending means status and mask both set
    assign req = |masked_of(PENDING_CAUSE_FLAGS, st_r.mask);

    always_comb
    begin
        st_nxt        = st_r;
        st_nxt.masked = masked_of(PENDING_CAUSE_FLAGS, st_r.mask);
        if (CAUSE_ENABLE_MASK_WE)
        begin
            st_nxt.mask = CAUSE_ENABLE_MASK_WR;
        end
        // Vector register is plain storage in either mode
        if (VECTOR_WE)
        begin
            st_nxt.vec = VECTOR_WR;
        end
        case (MODE_CMD)
            DISM_CMD_SET_VECTOR: st_nxt.vec_mode = 1'b1;
            DISM_CMD_SET_PLAIN:  st_nxt.vec_mode = 1'b0;
            default:             st_nxt.vec_mode = st_r.vec_mode;
        endcase
        // Held low while any enabled cause remains
        st_nxt.irq_n = !req;
        // In vector mode, chain passes on only when not requesting ourselves; plain mode always passes it
        st_nxt.prio_out_n = st_r.vec_mode ? (prio_in_n | req)
                                          : prio_in_n;
        st_nxt.oe   = 1'b0;
        st_nxt.dout = '0;
        if (st_r.vec_mode && !ack_n && !prio_in_n && req)
        begin
            st_nxt.oe   = 1'b1;
            st_nxt.dout = st_r.vec;
        end
        // Plain mode leaves vector to outside logic
    end

    always_ff @(posedge MCLK)
    begin
        if (!RESETN)
        begin
            st_r <= '{vec_mode:   1'b0,
                      vec:        DISM_VEC_RST,
                      mask:       CAUSE_W'(DISM_MASK_RST),
                      masked:     '0,
                      irq_n:      1'b1,
                      prio_out_n: 1'b1,
                      dout:       '0,
                      oe:         1'b0};
        end
        else
        begin
            st_r <= st_nxt;
        end
    end

    assign MASKED_CAUSE_FLAGS = st_r.masked;
    assign VECTOR_VALUE_REG   = st_r.vec;
    assign VECTOR_MODE        = st_r.vec_mode;
    assign PRIO_OUT_N         = st_r.prio_out_n;
    assign IRQ_OUT_N          = st_r.irq_n;
    assign DATA_OUT           = st_r.dout;
    assign DATA_OE            = st_r.oe;

    irq_follows_a: assert property (@(posedge MCLK) disable iff (!RESETN)
        1'b1 |=> IRQ_OUT_N == !$past(req))
        else $error("irq not following masked causes");
    plain_quiet_a: assert property (@(posedge MCLK) disable iff (!RESETN)
        !st_r.vec_mode |=> !DATA_OE)
        else $error("bus driven in plain mode");
    reset_plain_a: assert property (@(posedge MCLK)
        !RESETN |=> !VECTOR_MODE && IRQ_OUT_N && !DATA_OE)
        else $error("not plain after reset");
    mode_cmd_a: assert property (@(posedge MCLK) disable iff (!RESETN)
        (!VECTOR_MODE && MODE_CMD != DISM_CMD_SET_VECTOR) |=> !VECTOR_MODE)
        else $error("vector mode without command");
    vec_drive_a: assert property (@(posedge MCLK) disable iff (!RESETN)
        DATA_OE |-> DATA_OUT == $past(st_r.vec))
        else $error("wrong vector driven");
    oe_ack_a: assert property (@(posedge MCLK) disable iff (!RESETN)
        DATA_OE |-> $past(!ack_n))
        else $error("bus driven outside acknowledge");
    masked_and_a: assert property (@(posedge MCLK) disable iff (!RESETN)
        1'b1 |=> MASKED_CAUSE_FLAGS ==
                 $past(PENDING_CAUSE_FLAGS & st_r.mask))
        else $error("masked flags wrong");
    chain_block_a: assert property (@(posedge MCLK) disable iff (!RESETN)
        (VECTOR_MODE && req) |=> PRIO_OUT_N)
        else $error("chain passed while requesting");

    // Chain and vector drive conditions
    chain_pass_a: assert property (@(posedge MCLK) disable iff (!RESETN)
        !st_r.vec_mode |=> PRIO_OUT_N == $past(prio_in_n))
        else $error("chain not passed in plain mode");
    vec_prio_a: assert property (@(posedge MCLK) disable iff (!RESETN)
        DATA_OE |-> $past(!prio_in_n && st_r.vec_mode))
        else $error("vector driven without priority");
    oe_req_a: assert property (@(posedge MCLK) disable iff (!RESETN)
        DATA_OE |-> $past(req))
        else $error("vector driven without request");
    ack_drive_a: assert property (@(posedge MCLK) disable iff (!RESETN)
        (st_r.vec_mode && !ack_n && !prio_in_n && req) |=>
        (DATA_OE && DATA_OUT == $past(st_r.vec)))
        else $error("vector missing in acknowledge");
    dout_idle_a: assert property (@(posedge MCLK) disable iff (!RESETN)
        !DATA_OE |-> DATA_OUT == '0)
        else $error("data shown while released");

    // Request, registers and mode exit
    irq_low_a: assert property (@(posedge MCLK) disable iff (!RESETN)
        req |=> !IRQ_OUT_N)
        else $error("request not driven low");
    vec_write_a: assert property (@(posedge MCLK) disable iff (!RESETN)
        VECTOR_WE |=> VECTOR_VALUE_REG == $past(VECTOR_WR))
        else $error("vector write lost");
    mask_write_a: assert property (@(posedge MCLK) disable iff (!RESETN)
        CAUSE_ENABLE_MASK_WE |=> st_r.mask == $past(CAUSE_ENABLE_MASK_WR))
        else $error("mask write lost");
    plain_cmd_a: assert property (@(posedge MCLK) disable iff (!RESETN)
        MODE_CMD == DISM_CMD_SET_PLAIN |=> !VECTOR_MODE)
        else $error("plain command ignored");
endmodule
`default_nettype wire

// file: testbench/dism_host.sv
// Host model that acknowledges requests and captures the vector
`timescale 1ns/10ps
`default_nettype none
module dism_host
(
    // Clock and start
    input  wire logic       clk,
    input  wire logic       go,
    // Device side
    input  wire logic       irq_n,
    input  wire logic [7:0] data,
    input  wire logic       oe,
    output var  logic       ack_n,
    output var  logic [7:0] vec,
    output var  logic       got
);
    int cnt = 0;
    initial ack_n = 1'b1;
    initial vec = 8'h00;
    initial got = 1'b0;
    // Ack starts only when go and a request are seen, then is held low for ten cycles
    always @(posedge clk)
    begin
        if (cnt != 0)
        begin
            cnt <= cnt - 1;
            ack_n <= (cnt == 1);
            if (oe)
            begin
                vec <= data;
                got <= 1'b1;
            end
        end
        else if (go && !irq_n)
        begin
            cnt <= 10;
            ack_n <= 1'b0;
            got <= 1'b0;
        end
    end
endmodule
`default_nettype wire

// file: testbench/dism_top_tb.sv
// Self-checking bench for the interrupt service mode block
`timescale 1ns/10ps
`default_nettype none
module dism_top_tb;
    import dism_pkg::*;
    logic         clk = 0, rst_n = 0, mwe = 0, vwe = 0, prio_n = 1, go = 0;
    logic [7:0]   pend = 0, mwr = 0, vwr = 0;
    dism_cmd_type cmd = DISM_CMD_NONE;
    wire logic    irq_n, oe, vmode, ack_n, got, prio_out;
    wire logic [7:0] masked, vreg, dout, hvec;
    int           bad_count = 0;
    int           num_checks = 0;
    dism_top DUT (.MCLK(clk), .RESETN(rst_n), .PENDING_CAUSE_FLAGS(pend),
        .CAUSE_ENABLE_MASK_WR(mwr), .CAUSE_ENABLE_MASK_WE(mwe),
        .MASKED_CAUSE_FLAGS(masked), .MODE_CMD(cmd), .VECTOR_WR(vwr),
        .VECTOR_WE(vwe), .VECTOR_VALUE_REG(vreg), .VECTOR_MODE(vmode),
        .PRIO_IN_N(prio_n), .PRIO_OUT_N(prio_out), .HOST_INT_ACK_N(ack_n),
        .IRQ_OUT_N(irq_n), .DATA_OUT(dout), .DATA_OE(oe));
    dism_host host (.clk(clk), .go(go), .irq_n(irq_n), .data(dout),
        .oe(oe), .ack_n(ack_n), .vec(hvec), .got(got));
    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        num_checks++;
        if (seen !== exp)
        begin
            bad_count++;
            $display("mismatch at %0t: saw %h want %h", $time, seen, exp);
        end
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    task automatic wr(input logic [7:0] m, input logic [7:0] v);
        @(posedge clk);
        {mwr, vwr, mwe, vwe} <= {m, v, 2'b11};
        @(posedge clk);
        {mwe, vwe} <= 2'b00;
    endtask
    task automatic mode(input dism_cmd_type c);
        @(posedge clk);
        cmd <= c;
        @(posedge clk);
        cmd <= DISM_CMD_NONE;
    endtask
    // Long wait covers sync delay plus the whole ack window
    task automatic ack_once;
        @(posedge clk);
        go <= 1'b1;
        @(posedge clk);
        go <= 1'b0;
        cyc(20);
    endtask
    task automatic complete_run;
        $display("checks %0d mismatches %0d", num_checks, bad_count);
        if (bad_count == 0 && num_checks > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    task automatic t_reset;
        chk({7'h00, irq_n}, 8'h01);
        chk({7'h00, vmode}, 8'h00);
        chk({7'h00, oe}, 8'h00);
        chk(vreg, DISM_VEC_RST);
        chk({7'h00, prio_out}, 8'h01);
    endtask
    task automatic t_plain;
        wr(8'h05, 8'h40);
        pend <= 8'h0A;
        cyc(4);
        chk({7'h00, irq_n}, 8'h01);
        chk(vreg, 8'h40);
        pend <= 8'h0E;
        cyc(4);
        chk({7'h00, irq_n}, 8'h00);
        chk(masked, 8'h04);
        ack_once();
        chk({7'h00, got}, 8'h00);
        chk({7'h00, irq_n}, 8'h00);
        pend <= 8'h00;
        cyc(4);
        chk({7'h00, irq_n}, 8'h01);
    endtask
    task automatic t_vector;
        mode(DISM_CMD_SET_VECTOR);
        cyc(2);
        chk({7'h00, vmode}, 8'h01);
        pend <= 8'h04;
        cyc(4);
        ack_once();
        chk({7'h00, got}, 8'h00);
        prio_n <= 1'b0;
        ack_once();
        chk({7'h00, got}, 8'h01);
        chk(hvec, 8'h40);
        chk({7'h00, prio_out}, 8'h01);
        chk({7'h00, oe}, 8'h00);
        pend <= 8'h00;
        mode(DISM_CMD_SET_PLAIN);
        cyc(4);
        chk({7'h00, vmode}, 8'h00);
        chk({7'h00, irq_n}, 8'h01);
        chk({7'h00, prio_out}, 8'h00);
    endtask
    initial forever #50 clk = ~clk;
    // Run needs well under 400 cycles
    initial
    begin
        cyc(5000);
        bad_count++;
        complete_run();
    end
    initial
    begin
        repeat (20) @(posedge clk);
        rst_n <= 1'b1;
        cyc(2);
        t_reset();
        t_plain();
        t_vector();
        complete_run();
    end
endmodule
`default_nettype wire
